// ===== verilog/fsc_defs.svh
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define FSC_CLK_PERIOD_PS 5000

// ----------------------------------------
// Bus timing in ns (erase time in s), and derived cycles
// ----------------------------------------
`define FSC_T_WP_NS   90
`define FSC_T_WPH_NS  90
`define FSC_T_ACC_NS  120
`define FSC_T_OEHP_NS 150
`define FSC_T_EC_S    10
`define FSC_CYC(ns) (((ns) * 1000 + `FSC_CLK_PERIOD_PS - 1) / `FSC_CLK_PERIOD_PS)
`define FSC_WP_CYC   `FSC_CYC(`FSC_T_WP_NS)
`define FSC_WPH_CYC  `FSC_CYC(`FSC_T_WPH_NS)
`define FSC_ACC_CYC  `FSC_CYC(`FSC_T_ACC_NS)
`define FSC_OEHP_CYC `FSC_CYC(`FSC_T_OEHP_NS)
// Seconds to cycles, ordered so that no step leaves 32 bits
`define FSC_EC_CYC   (`FSC_T_EC_S * (1000000000 / `FSC_CLK_PERIOD_PS) * 1000)

// ----------------------------------------
// Command addresses and data
// ----------------------------------------
`define FSC_CMD_ADDR1   15'h5555
`define FSC_CMD_ADDR2   15'h2AAA
`define FSC_CMD_UNLOCK1 8'hAA
`define FSC_CMD_UNLOCK2 8'h55
`define FSC_CMD_PROG    8'hA0
`define FSC_CMD_ERASE   8'h80
`define FSC_CMD_CHIP    8'h10
`define FSC_CMD_ID_IN   8'h90
`define FSC_CMD_ID_OUT  8'hF0
`define FSC_CMD_LOCK    8'h40

// ----------------------------------------
// Sequence table start indices
// ----------------------------------------
`define FSC_IDX_PROG   5'h00
`define FSC_IDX_ERASE  5'h04
`define FSC_IDX_ID_IN  5'h0A
`define FSC_IDX_ID_OUT 5'h0D
`define FSC_IDX_LOCK   5'h10

// ----------------------------------------
// Layout
// ----------------------------------------
`define FSC_ADDR_W     17
`define FSC_BOOT_TOP   17'h01FFF
`define FSC_TOGGLE_BIT 6

`endif

// ===== verilog/fsc_pkg.sv
package fsc_pkg;

    typedef enum logic [2:0] {
        FSC_OP_READ,
        FSC_OP_PROGRAM,
        FSC_OP_ERASE,
        FSC_OP_ID_ENTER,
        FSC_OP_ID_EXIT,
        FSC_OP_ID_READ,
        FSC_OP_LOCK
    } fsc_op_t;

    typedef enum logic [3:0] {
        FSC_ST_IDLE,
        FSC_ST_FETCH,
        FSC_ST_APPLY,
        FSC_ST_WR_LO,
        FSC_ST_WR_HI,
        FSC_ST_RD,
        FSC_ST_POLL_RD,
        FSC_ST_POLL_HI,
        FSC_ST_DONE
    } fsc_state_t;

    typedef struct packed {
        logic        last;
        logic        user;
        logic [14:0] addr;
        logic [7:0]  data;
    } fsc_entry_t;

endpackage

// ===== verilog/fsc_seq_if.sv
`timescale 1ns/100ps
interface fsc_seq_if;
    logic [4:0]          idx;
    fsc_pkg::fsc_entry_t entry;

    modport ctrl (output idx, input entry);
    modport rom  (input idx, output entry);
endinterface

// ===== verilog/fsc_seq_rom.sv
`timescale 1ns/100ps
`include "fsc_defs.svh"

module fsc_seq_rom (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_resetn,
    // Table port
    fsc_seq_if.rom    seq
);

    // ----------------------------------------
    // Command sequence table
    // ----------------------------------------
    function automatic fsc_pkg::fsc_entry_t seq_entry(input logic [4:0] idx);
        fsc_pkg::fsc_entry_t e;
        e = '0;
        unique case (idx)
            5'h00, 5'h04, 5'h07, 5'h0A, 5'h0D, 5'h10, 5'h13:
                e = '{1'b0, 1'b0, `FSC_CMD_ADDR1, `FSC_CMD_UNLOCK1};
            5'h01, 5'h05, 5'h08, 5'h0B, 5'h0E, 5'h11, 5'h14:
                e = '{1'b0, 1'b0, `FSC_CMD_ADDR2, `FSC_CMD_UNLOCK2};
            5'h02: e = '{1'b0, 1'b0, `FSC_CMD_ADDR1, `FSC_CMD_PROG};
            5'h03: e = '{1'b1, 1'b1, 15'h0000, 8'h00};
            5'h06, 5'h12: e = '{1'b0, 1'b0, `FSC_CMD_ADDR1, `FSC_CMD_ERASE};
            5'h09: e = '{1'b1, 1'b0, `FSC_CMD_ADDR1, `FSC_CMD_CHIP};
            5'h0C: e = '{1'b1, 1'b0, `FSC_CMD_ADDR1, `FSC_CMD_ID_IN};
            5'h0F: e = '{1'b1, 1'b0, `FSC_CMD_ADDR1, `FSC_CMD_ID_OUT};
            5'h15: e = '{1'b1, 1'b0, `FSC_CMD_ADDR1, `FSC_CMD_LOCK};
            // Unused slots end any sequence safely
            default: e = '{1'b1, 1'b0, 15'h0000, 8'h00};
        endcase
        return e;
    endfunction

    fsc_pkg::fsc_entry_t entry_r;
    fsc_pkg::fsc_entry_t entry_nxt;

    always_comb begin
        entry_nxt = seq_entry(seq.idx);
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            entry_r <= '0;
        end else begin
            entry_r <= entry_nxt;
        end
    end

    assign seq.entry = entry_r;

endmodule // fsc_seq_rom

// ===== verilog/fsc_host.sv
// What this block does
// - Poll by pulsing read strobe, chip select held
// - Read strobe high 150 ns between polls
// - Ignore toggle value; compare successive reads only
// - Same address on every poll read
// - Identification read: upper lines low, lowest selects
// - Command addresses bits 14..0, data eight lines
// - Every sequence starts AA to 5555
// - Read strobe high during all write pulses
`timescale 1ns/100ps
`include "fsc_defs.svh"

module fsc_host #(
    parameter int unsigned POLL_TMO_CYC = `FSC_EC_CYC
) (
    // Clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_resetn,
    // User command port
    input  wire logic                   i_req,
    input  wire logic [2:0]             i_op,
    input  wire logic [`FSC_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]             i_wdata,
    output logic                        o_busy,
    output logic                        o_done,
    output logic [7:0]                  o_rdata,
    output logic                        o_err,
    output logic                        o_timeout,
    output logic                        o_id_mode,
    output logic                        o_lock_sent,
    // Flash pins
    output logic                        o_flash_ce_n,
    output logic                        o_flash_oe_n,
    output logic                        o_flash_we_n,
    output logic [`FSC_ADDR_W-1:0]      o_flash_addr,
    output logic [7:0]                  o_flash_dq_out,
    output logic                        o_flash_dq_oe,
    input  wire logic [7:0]             i_flash_dq_in
);

    // Write strobe needs one extra count: it drops one cycle into the low phase
    localparam logic [7:0] WP_CYC   = 8'(`FSC_WP_CYC);
    localparam logic [7:0] WPH_CYC  = 8'(`FSC_WPH_CYC - 1);
    localparam logic [7:0] ACC_CYC  = 8'(`FSC_ACC_CYC - 1);
    localparam logic [7:0] OEHP_CYC = 8'(`FSC_OEHP_CYC - 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [4:0] seq_start(input fsc_pkg::fsc_op_t op);
        unique case (op)
            fsc_pkg::FSC_OP_PROGRAM:  seq_start = `FSC_IDX_PROG;
            fsc_pkg::FSC_OP_ERASE:    seq_start = `FSC_IDX_ERASE;
            fsc_pkg::FSC_OP_ID_ENTER: seq_start = `FSC_IDX_ID_IN;
            fsc_pkg::FSC_OP_ID_EXIT:  seq_start = `FSC_IDX_ID_OUT;
            default:                  seq_start = `FSC_IDX_LOCK;
        endcase
    endfunction

    function automatic logic needs_poll(input fsc_pkg::fsc_op_t op);
        needs_poll = (op == fsc_pkg::FSC_OP_PROGRAM) || (op == fsc_pkg::FSC_OP_ERASE) ||
                     (op == fsc_pkg::FSC_OP_LOCK);
    endfunction

    // ----------------------------------------
    // Sequence table
    // ----------------------------------------
    fsc_seq_if seq ();

    fsc_seq_rom u_rom (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .seq       (seq.rom)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    fsc_pkg::fsc_state_t       st_r,    st_nxt;
    fsc_pkg::fsc_op_t          op_r,    op_nxt;
    logic [7:0]                tmr_r,   tmr_nxt;
    logic [31:0]               pto_r,   pto_nxt;
    logic [4:0]                idx_r,   idx_nxt;
    logic [`FSC_ADDR_W-1:0]    uaddr_r, uaddr_nxt;
    logic [7:0]                uwd_r,   uwd_nxt;
    logic                      first_r, first_nxt;
    logic                      tog_r,   tog_nxt;
    logic                      ce_r,    ce_nxt;
    logic                      oe_r,    oe_nxt;
    logic                      we_r,    we_nxt;
    logic [`FSC_ADDR_W-1:0]    addr_r,  addr_nxt;
    logic [7:0]                dq_r,    dq_nxt;
    logic                      dqoe_r,  dqoe_nxt;
    logic                      busy_r,  busy_nxt;
    logic                      done_r,  done_nxt;
    logic [7:0]                rd_r,    rd_nxt;
    logic                      err_r,   err_nxt;
    logic                      tout_r,  tout_nxt;
    logic                      idm_r,   idm_nxt;
    logic                      lock_r,  lock_nxt;
    fsc_pkg::fsc_op_t          req_op;

    assign seq.idx = idx_r;
    assign req_op  = (i_op == 3'h7) ? fsc_pkg::FSC_OP_LOCK : fsc_pkg::fsc_op_t'(i_op);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt    = st_r;
        op_nxt    = op_r;
        tmr_nxt   = tmr_r;
        pto_nxt   = pto_r;
        idx_nxt   = idx_r;
        uaddr_nxt = uaddr_r;
        uwd_nxt   = uwd_r;
        first_nxt = first_r;
        tog_nxt   = tog_r;
        ce_nxt    = ce_r;
        oe_nxt    = oe_r;
        we_nxt    = we_r;
        addr_nxt  = addr_r;
        dq_nxt    = dq_r;
        dqoe_nxt  = dqoe_r;
        busy_nxt  = busy_r;
        done_nxt  = 1'b0;
        rd_nxt    = rd_r;
        err_nxt   = err_r;
        tout_nxt  = tout_r;
        idm_nxt   = idm_r;
        lock_nxt  = lock_r;
        unique case (st_r)
            fsc_pkg::FSC_ST_IDLE: begin
                if (i_req) begin
                    op_nxt    = req_op;
                    uaddr_nxt = i_addr;
                    uwd_nxt   = i_wdata;
                    err_nxt   = 1'b0;
                    tout_nxt  = 1'b0;
                    if (req_op == fsc_pkg::FSC_OP_PROGRAM && lock_r && i_addr <= `FSC_BOOT_TOP) begin
                        // Locked boot block would silently ignore it
                        err_nxt  = 1'b1;
                        done_nxt = 1'b1;
                    end else if (req_op == fsc_pkg::FSC_OP_READ || req_op == fsc_pkg::FSC_OP_ID_READ) begin
                        addr_nxt = (req_op == fsc_pkg::FSC_OP_ID_READ) ?
                                   {{(`FSC_ADDR_W-1){1'b0}}, i_addr[0]} : i_addr;
                        ce_nxt   = 1'b0;
                        oe_nxt   = 1'b0;
                        tmr_nxt  = ACC_CYC;
                        busy_nxt = 1'b1;
                        st_nxt   = fsc_pkg::FSC_ST_RD;
                    end else begin
                        idx_nxt  = seq_start(req_op);
                        busy_nxt = 1'b1;
                        st_nxt   = fsc_pkg::FSC_ST_FETCH;
                    end
                end
            end
            fsc_pkg::FSC_ST_FETCH: begin
                st_nxt = fsc_pkg::FSC_ST_APPLY;
            end
            fsc_pkg::FSC_ST_APPLY: begin
                addr_nxt = seq.entry.user ? uaddr_r : {2'b00, seq.entry.addr};
                dq_nxt   = seq.entry.user ? uwd_r : seq.entry.data;
                dqoe_nxt = 1'b1;
                ce_nxt   = 1'b0;
                oe_nxt   = 1'b1;
                tmr_nxt  = WP_CYC;
                st_nxt   = fsc_pkg::FSC_ST_WR_LO;
            end
            fsc_pkg::FSC_ST_WR_LO: begin
                we_nxt = 1'b0;
                if (tmr_r == 8'h00) begin
                    we_nxt  = 1'b1;
                    tmr_nxt = WPH_CYC;
                    st_nxt  = fsc_pkg::FSC_ST_WR_HI;
                end else begin
                    tmr_nxt = tmr_r - 8'h01;
                end
            end
            fsc_pkg::FSC_ST_WR_HI: begin
                if (tmr_r != 8'h00) begin
                    tmr_nxt = tmr_r - 8'h01;
                end else if (!seq.entry.last) begin
                    idx_nxt = idx_r + 5'h01;
                    st_nxt  = fsc_pkg::FSC_ST_FETCH;
                end else begin
                    dqoe_nxt = 1'b0;
                    if (op_r == fsc_pkg::FSC_OP_ID_ENTER) idm_nxt = 1'b1;
                    if (op_r == fsc_pkg::FSC_OP_ID_EXIT) idm_nxt = 1'b0;
                    if (op_r == fsc_pkg::FSC_OP_LOCK) lock_nxt = 1'b1;
                    if (needs_poll(op_r)) begin
                        // One fixed address for the whole poll
                        addr_nxt  = (op_r == fsc_pkg::FSC_OP_PROGRAM) ? uaddr_r : '0;
                        oe_nxt    = 1'b0;
                        first_nxt = 1'b1;
                        pto_nxt   = '0;
                        tmr_nxt   = ACC_CYC;
                        st_nxt    = fsc_pkg::FSC_ST_POLL_RD;
                    end else begin
                        st_nxt = fsc_pkg::FSC_ST_DONE;
                    end
                end
            end
            fsc_pkg::FSC_ST_RD: begin
                if (tmr_r == 8'h00) begin
                    rd_nxt = i_flash_dq_in;
                    oe_nxt = 1'b1;
                    st_nxt = fsc_pkg::FSC_ST_DONE;
                end else begin
                    tmr_nxt = tmr_r - 8'h01;
                end
            end
            fsc_pkg::FSC_ST_POLL_RD: begin
                pto_nxt = pto_r + 32'h0000_0001;
                if (tmr_r == 8'h00) begin
                    rd_nxt    = i_flash_dq_in;
                    tog_nxt   = i_flash_dq_in[`FSC_TOGGLE_BIT];
                    first_nxt = 1'b0;
                    oe_nxt    = 1'b1;
                    tmr_nxt   = OEHP_CYC;
                    st_nxt    = fsc_pkg::FSC_ST_POLL_HI;
                    if (!first_r && i_flash_dq_in[`FSC_TOGGLE_BIT] == tog_r) begin
                        st_nxt = fsc_pkg::FSC_ST_DONE;
                    end
                end else begin
                    tmr_nxt = tmr_r - 8'h01;
                end
            end
            fsc_pkg::FSC_ST_POLL_HI: begin
                pto_nxt = pto_r + 32'h0000_0001;
                if (pto_r >= POLL_TMO_CYC) begin
                    tout_nxt = 1'b1;
                    err_nxt  = 1'b1;
                    st_nxt   = fsc_pkg::FSC_ST_DONE;
                end else if (tmr_r == 8'h00) begin
                    oe_nxt  = 1'b0;
                    tmr_nxt = ACC_CYC;
                    st_nxt  = fsc_pkg::FSC_ST_POLL_RD;
                end else begin
                    tmr_nxt = tmr_r - 8'h01;
                end
            end
            fsc_pkg::FSC_ST_DONE: begin
                ce_nxt   = 1'b1;
                oe_nxt   = 1'b1;
                we_nxt   = 1'b1;
                dqoe_nxt = 1'b0;
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                st_nxt   = fsc_pkg::FSC_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r    <= fsc_pkg::FSC_ST_IDLE;
            op_r    <= fsc_pkg::FSC_OP_READ;
            tmr_r   <= 8'h00;
            pto_r   <= 32'h0000_0000;
            idx_r   <= 5'h00;
            uaddr_r <= '0;
            uwd_r   <= 8'h00;
            first_r <= 1'b0;
            tog_r   <= 1'b0;
            ce_r    <= 1'b1;
            oe_r    <= 1'b1;
            we_r    <= 1'b1;
            addr_r  <= '0;
            dq_r    <= 8'h00;
            dqoe_r  <= 1'b0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            rd_r    <= 8'h00;
            err_r   <= 1'b0;
            tout_r  <= 1'b0;
            // Device leaves identification mode at power loss
            idm_r   <= 1'b0;
            lock_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            op_r    <= op_nxt;
            tmr_r   <= tmr_nxt;
            pto_r   <= pto_nxt;
            idx_r   <= idx_nxt;
            uaddr_r <= uaddr_nxt;
            uwd_r   <= uwd_nxt;
            first_r <= first_nxt;
            tog_r   <= tog_nxt;
            ce_r    <= ce_nxt;
            oe_r    <= oe_nxt;
            we_r    <= we_nxt;
            addr_r  <= addr_nxt;
            dq_r    <= dq_nxt;
            dqoe_r  <= dqoe_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
            rd_r    <= rd_nxt;
            err_r   <= err_nxt;
            tout_r  <= tout_nxt;
            idm_r   <= idm_nxt;
            lock_r  <= lock_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_busy         = busy_r;
    assign o_done         = done_r;
    assign o_rdata        = rd_r;
    assign o_err          = err_r;
    assign o_timeout      = tout_r;
    assign o_id_mode      = idm_r;
    assign o_lock_sent    = lock_r;
    assign o_flash_ce_n   = ce_r;
    assign o_flash_oe_n   = oe_r;
    assign o_flash_we_n   = we_r;
    assign o_flash_addr   = addr_r;
    assign o_flash_dq_out = dq_r;
    assign o_flash_dq_oe  = dqoe_r;

endmodule // fsc_host

// ===== testbench/fsc_host_asserts.sv
`timescale 1ns/100ps
module fsc_host_asserts (
    // Clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_resetn,
    // User port
    input wire logic        i_req,
    input wire logic [2:0]  i_op,
    input wire logic [16:0] i_addr,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_err,
    input wire logic        o_id_mode,
    input wire logic        o_lock_sent,
    // Flash pins
    input wire logic        o_flash_ce_n,
    input wire logic        o_flash_oe_n,
    input wire logic        o_flash_we_n,
    input wire logic [16:0] o_flash_addr,
    input wire logic [7:0]  o_flash_dq_out,
    input wire logic        o_flash_dq_oe
);
    // ------------------------------
    // Poll read tracking
    // ------------------------------
    logic [7:0]  hi_cnt_r, hi_cnt_nxt;
    logic [16:0] poll_a_r, poll_a_nxt;
    logic        seen_r, seen_nxt, pstart, take;
    assign take   = i_req && !o_busy && !o_done;
    assign pstart = !o_flash_ce_n && !o_flash_oe_n && hi_cnt_r != 8'h00;
    always_comb begin
        hi_cnt_nxt = 8'h00;
        if (!o_flash_ce_n && o_flash_oe_n) begin
            hi_cnt_nxt = (hi_cnt_r == 8'hFF) ? hi_cnt_r : hi_cnt_r + 8'h01;
        end
        seen_nxt   = !o_flash_ce_n && (seen_r || pstart);
        poll_a_nxt = pstart ? o_flash_addr : poll_a_r;
    end
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hi_cnt_r <= 8'h00;
            seen_r   <= 1'b0;
            poll_a_r <= 17'h00000;
        end else begin
            hi_cnt_r <= hi_cnt_nxt;
            seen_r   <= seen_nxt;
            poll_a_r <= poll_a_nxt;
        end
    end
    // ------------------------------
    // Checks
    // ------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_unlock;
        o_flash_addr == 17'h05555 && o_flash_dq_out == 8'hAA && o_flash_dq_oe;
    endsequence
    sequence s_unlock_pulse;
        (!o_flash_we_n && o_flash_dq_out == 8'hAA)[*8];
    endsequence
    a_poll_gap: assert property (pstart |-> hi_cnt_r >= 8'h1E)
        else $error("read strobe high gap between polls too short");
    a_poll_addr: assert property (pstart && seen_r |-> o_flash_addr == poll_a_r)
        else $error("poll address moved");
    a_oe_in_write: assert property (!o_flash_we_n |-> o_flash_oe_n && !o_flash_ce_n && o_flash_dq_oe)
        else $error("read strobe low during write pulse");
    a_unlock_first: assert property ($fell(o_flash_ce_n) && o_flash_dq_oe |-> s_unlock ##1 s_unlock_pulse)
        else $error("sequence does not open with unlock write");
    a_ce_at_done: assert property ($rose(o_flash_ce_n) |-> o_done)
        else $error("chip select released before done");
    a_boot_refuse: assert property (take && i_op == 3'h1 && o_lock_sent && i_addr <= 17'h01FFF
        |-> ##1 (o_done && o_err && o_flash_ce_n))
        else $error("program into locked boot block not refused");
    a_id_read: assert property (take && i_op == 3'h5
        |=> o_flash_addr == {16'h0000, $past(i_addr[0])} ##25 o_done)
        else $error("identification read address or timing wrong");
    a_id_exit: assert property (take && i_op == 3'h4 |-> ##[1:300] (o_done && !o_id_mode))
        else $error("identification mode not left");
    a_lock_hold: assert property (o_lock_sent |=> o_lock_sent)
        else $error("lock flag dropped without reset");
endmodule // fsc_host_asserts

bind fsc_host fsc_host_asserts u_fsc_chk (.*);

// ===== testbench/fsc_flash_model.sv
`timescale 1ns/100ps
module fsc_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'hC3, // Arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h4D, // Arbitrary value
    parameter int         BUSY_READS = 3
) (
    // Bus pins
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [16:0] i_addr,
    input  wire logic [7:0]  i_dq,
    output logic [7:0]       o_dq,
    // Supply and fault control
    input  wire logic        i_power,
    input  wire logic        i_stuck
);
    logic [7:0] mem [0:131071];
    logic [7:0] q;
    logic [1:0] step;
    logic       prog, ext, idm, lock, tog;
    int         busy;
    // No pull on the data lines: a released bus shows the inverse
    assign o_dq = (!i_ce_n && !i_oe_n && i_we_n) ? q : ~q;
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5A;
        {step, prog, ext, idm, lock, tog, q} = '0;
        busy = 0;
    end
    always @(posedge i_we_n) begin
        if (!i_ce_n && prog) begin
            prog = 1'b0;
            if (!(lock && i_addr <= 17'h01FFF)) begin
                mem[i_addr] = mem[i_addr] & i_dq;
                busy = BUSY_READS;
            end
        end else if (!i_ce_n && step == 2'h2) begin
            step = 2'h0;
            prog = (i_dq == 8'hA0);
            if (ext && i_dq == 8'h10) begin
                for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
                busy = BUSY_READS;
            end
            if (ext && i_dq == 8'h40) begin
                lock = 1'b1;
                busy = BUSY_READS;
            end
            if (i_dq == 8'h90) idm = 1'b1;
            if (i_dq == 8'hF0) idm = 1'b0;
            ext = (i_dq == 8'h80);
        end else if (!i_ce_n) begin
            step = (step == 2'h0 && i_addr[14:0] == 15'h5555 && i_dq == 8'hAA) ? 2'h1 :
                   (step == 2'h1 && i_addr[14:0] == 15'h2AAA && i_dq == 8'h55) ? 2'h2 : 2'h0;
        end
    end
    // Output settles shortly after the strobe, like a real access
    always @(negedge i_oe_n or negedge i_ce_n) begin
        #1;
        if (!i_oe_n && !i_ce_n && i_we_n) begin
            if (busy > 0) begin
                tog = ~tog;
                q = {~mem[i_addr][7], tog, 6'h00};
                if (!i_stuck) busy = busy - 1;
            end else if (idm && i_addr[16:1] == 16'h0000) begin
                q = i_addr[0] ? PART_CODE : MAKER_CODE;
            end else begin
                q = mem[i_addr];
            end
        end
    end
    always @(negedge i_power) begin
        idm = 1'b0;
        step = 2'h0;
    end
endmodule // fsc_flash_model

// ===== testbench/fsc_host_tb.sv
`timescale 1ns/100ps
module fsc_host_tb;
    localparam int         TMO   = 2000;
    localparam logic [7:0] MAKER = 8'hC3; // Arbitrary identity value
    localparam logic [7:0] PART  = 8'h4D; // Arbitrary identity value
    typedef struct packed {
        logic [2:0]  op;
        logic [16:0] a;
        logic [7:0]  d;
        logic        chk;
        logic [7:0]  rd;
        logic        err;
        logic        idm;
    } fsc_row_t;
    logic        i_sys_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        i_req = 1'b0;
    logic [2:0]  i_op = 3'h0;
    logic [16:0] i_addr = 17'h00000;
    logic [7:0]  i_wdata = 8'h00;
    logic        o_busy, o_done, o_err, o_timeout, o_id_mode, o_lock_sent;
    logic        o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_dq_oe;
    logic [16:0] o_flash_addr;
    logic [7:0]  o_rdata, o_flash_dq_out, i_flash_dq_in, mdl_dq;
    logic        pwr = 1'b1;
    logic        stuck = 1'b0;
    int          n_mismatch = 0;
    int          checks = 0;
    fsc_row_t    rows [14];

    always #2.5 i_sys_clk = ~i_sys_clk;
    assign i_flash_dq_in = o_flash_dq_oe ? o_flash_dq_out : mdl_dq;
    fsc_host #(.POLL_TMO_CYC(TMO)) dut (.*);
    fsc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (
        .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n), .i_we_n(o_flash_we_n),
        .i_addr(o_flash_addr), .i_dq(i_flash_dq_in), .o_dq(mdl_dq),
        .i_power(pwr), .i_stuck(stuck)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_req   <= 1'b1;
        i_op    <= op;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_req <= 1'b0;
        while (o_done !== 1'b1 && n < 20000) begin
            @(posedge i_sys_clk);
            n++;
        end
        if (n == 20000) n_mismatch++;
    endtask
    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ------------------------------
    // Sequence
    // ------------------------------
    initial begin
        // Untouched array holds address low byte xor 5A
        rows = '{'{3'h0, 17'h00123, 8'h00, 1'b1, 8'h79, 1'b0, 1'b0},
                 '{3'h1, 17'h00123, 8'h3C, 1'b1, 8'h38, 1'b0, 1'b0},
                 '{3'h0, 17'h00123, 8'h00, 1'b1, 8'h38, 1'b0, 1'b0},
                 '{3'h3, 17'h00000, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1},
                 '{3'h5, 17'h00000, 8'h00, 1'b1, MAKER, 1'b0, 1'b1},
                 '{3'h5, 17'h00001, 8'h00, 1'b1, PART,  1'b0, 1'b1},
                 '{3'h4, 17'h00000, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
                 '{3'h0, 17'h00000, 8'h00, 1'b1, 8'h5A, 1'b0, 1'b0},
                 '{3'h2, 17'h00000, 8'h00, 1'b1, 8'hFF, 1'b0, 1'b0},
                 '{3'h0, 17'h1FFFF, 8'h00, 1'b1, 8'hFF, 1'b0, 1'b0},
                 '{3'h6, 17'h00000, 8'h00, 1'b1, 8'hFF, 1'b0, 1'b0},
                 '{3'h1, 17'h01FFF, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0},
                 '{3'h1, 17'h02000, 8'h12, 1'b1, 8'h12, 1'b0, 1'b0},
                 '{3'h0, 17'h02000, 8'h00, 1'b1, 8'h12, 1'b0, 1'b0}};
        repeat (3) @(posedge i_sys_clk);
        check({o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_dq_oe, o_busy, o_done, o_id_mode, o_lock_sent}, 8'hE0);
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        foreach (rows[k]) begin
            run(rows[k].op, rows[k].a, rows[k].d);
            if (rows[k].chk) check(o_rdata, rows[k].rd);
            check({7'h00, o_err}, {7'h00, rows[k].err});
            check({7'h00, o_id_mode}, {7'h00, rows[k].idm});
        end
        check({7'h00, o_lock_sent}, 8'h01);
        // Supply loss while identifying
        run(3'h3, 17'h00000, 8'h00);
        pwr      <= 1'b0;
        i_resetn <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        check({o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_dq_oe, o_busy, o_done, o_id_mode, o_lock_sent}, 8'hE0);
        pwr      <= 1'b1;
        i_resetn <= 1'b1;
        run(3'h0, 17'h00001, 8'h00);
        check(o_rdata, 8'hFF);
        // Host forgets the lockout over reset, the device keeps it
        run(3'h1, 17'h00100, 8'h00);
        check(o_rdata, 8'hFF);
        // Device never settles: the poll must give up
        stuck <= 1'b1;
        run(3'h1, 17'h02001, 8'h00);
        check({6'h00, o_err, o_timeout}, 8'h03);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule // fsc_host_tb
